// ---- hdl/line_side_io.sv ----
// Purpose: line-side serial pins and reference timing inputs
// Assumes: all pin clocks run well below half of ref_clk
// Notes: every pin edge is found by sampling; output clock is regenerated
`timescale 1ns/1ps
`default_nettype none
module line_side_io
    import line_side_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire line_cfg_t cfg,
    input wire logic rx_line_clock_in,
    input wire logic rx_line_serial_in,
    input wire logic rx_line_frame_pulse,
    input wire logic ext_loss_of_signal_n,
    input wire logic internal_los,
    input wire logic rx_ref_clock_in,
    input wire logic rx_ref_frame_in,
    input wire logic tx_line_clock_in,
    input wire logic tx_frame_ref_in,
    input wire logic datacom_ref_clock_in,
    input wire logic datacom_ref_frame_in,
    input wire logic tx_terminal_serial_clock,
    input wire logic framing_match,
    input wire logic framing_lost,
    input wire logic tx_bit_in,
    output logic rx_bit,
    output logic rx_bit_valid,
    output logic rx_line_frame_mark,
    output logic rx_term_tick,
    output logic rx_term_sof,
    output logic tx_line_clock_out,
    output logic tx_line_serial_out,
    output logic tx_bit_req,
    output logic tx_line_sof,
    output logic tx_term_tick,
    output logic tx_term_sof,
    output line_status_t status
);
    typedef enum {ST_IN_FRAME, ST_OUT_OF_FRAME} frame_state_t;

    logic [PIN_COUNT-1:0] pins;
    logic [PIN_COUNT-1:0] lvl;
    logic [PIN_COUNT-1:0] rise;
    logic [PIN_COUNT-1:0] fall;

    logic rx_bit_r;
    logic rx_bit_valid_r;
    logic rx_frame_mark_r;
    logic frame_pulse_used_r;
    frame_state_t frame_state_r;
    logic [1:0] match_cnt_r;
    logic [1:0] exit_need;
    logic los_r;
    logic [7:0] no_clk_cnt_r;
    logic [3:0] ext_low_cnt_r;
    logic rx_src_rise;
    logic rx_frame_active;
    logic [12:0] rx_term_cnt_r;
    logic [12:0] rx_term_last;
    logic rx_term_tick_r;
    logic rx_term_sof_r;
    logic tx_src_level;
    logic tx_src_fall;
    logic tx_clk_r;
    logic tx_data_r;
    logic tx_req_r;
    logic [12:0] tx_line_cnt_r;
    logic tx_line_sof_r;
    logic datacom_mode;
    logic dc_frame_active;
    logic tx_term_tick_r;
    logic tx_term_sof_r;

    // turn a sampled pin into an active-high event, low-true when asked
    function automatic logic pulse_active(input logic level_in, input logic low_true);
        pulse_active = low_true ? ~level_in : level_in;
    endfunction : pulse_active

    // frame length in reference ticks for a given reference rate
    function automatic logic [12:0] frame_len(input ref_rate_t rate);
        unique case (rate)
            RATE_51M84: frame_len = FRAME_BITS;
            RATE_19M44: frame_len = FRAME_BYTES_19M44;
            RATE_6M48: frame_len = FRAME_BYTES_6M48;
            default: frame_len = FRAME_BITS;
        endcase
    endfunction : frame_len

    // fixed low-true pins enter inverted so a cleared sampler reads them as idle after reset
    assign pins = {tx_terminal_serial_clock, datacom_ref_frame_in, datacom_ref_clock_in,
                   ~tx_frame_ref_in, tx_line_clock_in, rx_ref_frame_in, rx_ref_clock_in,
                   ~ext_loss_of_signal_n, ~rx_line_frame_pulse, rx_line_serial_in,
                   rx_line_clock_in};

    pin_sampler #(.WIDTH(PIN_COUNT)) u_pins (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .pin(pins),
        .level(lvl),
        .rise(rise),
        .fall(fall)
    );

    // receive line data and frame pulse, both taken at the line clock rise
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rx_bit_r <= 1'b0;
            rx_bit_valid_r <= 1'b0;
            rx_frame_mark_r <= 1'b0;
        end else begin
            rx_bit_valid_r <= rise[PIN_RX_CLK];
            rx_frame_mark_r <= 1'b0;
            if (rise[PIN_RX_CLK]) begin
                rx_bit_r <= lvl[PIN_RX_DATA];
                // pulse is low during C1 bit 7; ignored in single-channel mode
                rx_frame_mark_r <= ~cfg.single_channel_mode_bit & lvl[PIN_RX_FRAME];
            end
        end
    end

    // the pulse counts as in use once seen while the input is enabled
    always_ff @(posedge ref_clk) begin
        if (!rst_n || cfg.single_channel_mode_bit) begin
            frame_pulse_used_r <= 1'b0;
        end else if (rx_frame_mark_r) begin
            frame_pulse_used_r <= 1'b1;
        end
    end

    // a known frame position lets the framer trust a single good frame
    assign exit_need = frame_pulse_used_r ? OOF_EXIT_WITH_PULSE : OOF_EXIT_NORMAL;

    // out-of-frame tracking; a loss in the same cycle as a match wins
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            frame_state_r <= ST_OUT_OF_FRAME;
            match_cnt_r <= 2'h0;
        end else begin
            unique case (frame_state_r)
                ST_IN_FRAME: begin
                    match_cnt_r <= 2'h0;
                    if (framing_lost) begin
                        frame_state_r <= ST_OUT_OF_FRAME;
                    end
                end
                ST_OUT_OF_FRAME: begin
                    if (framing_lost) begin
                        match_cnt_r <= 2'h0;
                    end else if (framing_match) begin
                        if (match_cnt_r + 2'h1 >= exit_need) begin
                            frame_state_r <= ST_IN_FRAME;
                            match_cnt_r <= 2'h0;
                        end else begin
                            match_cnt_r <= match_cnt_r + 2'h1;
                        end
                    end
                end
            endcase
        end
    end

    // internal detector: line clock has stopped toggling
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            no_clk_cnt_r <= 8'h00;
        end else if (rise[PIN_RX_CLK]) begin
            no_clk_cnt_r <= 8'h00;
        end else if (no_clk_cnt_r != NO_CLK_CYC) begin
            no_clk_cnt_r <= no_clk_cnt_r + 8'h01;
        end
    end

    // a low shorter than one sample period can slip between samples
    always_ff @(posedge ref_clk) begin
        if (!rst_n || !lvl[PIN_EXT_LOS_N]) begin
            ext_low_cnt_r <= 4'h0;
        end else if (ext_low_cnt_r != LOS_MIN_LOW_CYC) begin
            ext_low_cnt_r <= ext_low_cnt_r + 4'h1;
        end
    end

    // combined loss status from sampled pin levels plus the unsynchronised internal_los
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            los_r <= 1'b0;
        end else begin
            los_r <= (ext_low_cnt_r == LOS_MIN_LOW_CYC) | internal_los |
                     (no_clk_cnt_r == NO_CLK_CYC);
        end
    end

    // receive terminal timing from reference clock only when selected
    assign rx_src_rise = cfg.rx_ref_clock_select ? rise[PIN_RREF_CLK]
                                                 : rise[PIN_RX_CLK];
    assign rx_frame_active = pulse_active(lvl[PIN_RREF_FRAME],
                                          cfg.rx_ref_rate == RATE_51M84);
    assign rx_term_last = frame_len(cfg.rx_ref_rate) - 13'h0001;

    // free-running frame count; without a reference pulse the start is arbitrary
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rx_term_cnt_r <= 13'h0000;
            rx_term_tick_r <= 1'b0;
            rx_term_sof_r <= 1'b0;
        end else begin
            rx_term_tick_r <= rx_src_rise;
            rx_term_sof_r <= 1'b0;
            if (rx_src_rise) begin
                if ((cfg.rx_ref_clock_select && rx_frame_active) ||
                    rx_term_cnt_r >= rx_term_last) begin
                    rx_term_cnt_r <= 13'h0000;
                    rx_term_sof_r <= 1'b1;
                end else begin
                    rx_term_cnt_r <= rx_term_cnt_r + 13'h0001;
                end
            end
        end
    end

    // transmit clock source: line clock input if selected, else by mode
    always_comb begin
        tx_src_level = lvl[PIN_TX_CLK];
        tx_src_fall = fall[PIN_TX_CLK];
        if (!cfg.tx_clock_source_select) begin
            unique case (cfg.tx_mode)
                TXM_SONET: begin
                    tx_src_level = lvl[PIN_TERM_CLK];
                    tx_src_fall = fall[PIN_TERM_CLK];
                end
                TXM_LOOP: begin
                    tx_src_level = lvl[PIN_RX_CLK];
                    tx_src_fall = fall[PIN_RX_CLK];
                end
                TXM_DC_SERIAL, TXM_DC_PARALLEL: begin
                    tx_src_level = lvl[PIN_DC_CLK];
                    tx_src_fall = fall[PIN_DC_CLK];
                end
            endcase
        end
    end

    // clock and data leave from flops in the same cycle, so data moves on the fall
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            tx_clk_r <= 1'b0;
            tx_data_r <= 1'b0;
            tx_req_r <= 1'b0;
        end else begin
            tx_clk_r <= tx_src_level & ~tx_src_fall;
            tx_req_r <= tx_src_fall;
            if (tx_src_fall) begin
                tx_data_r <= tx_bit_in;
            end
        end
    end

    // transmit line frame counter, realigned by the low reference pulse
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            tx_line_cnt_r <= 13'h0000;
            tx_line_sof_r <= 1'b0;
        end else begin
            tx_line_sof_r <= 1'b0;
            if (tx_src_fall) begin
                if ((cfg.tx_frame_align_en && lvl[PIN_TX_FRAME_N]) ||
                    tx_line_cnt_r == FRAME_BITS - 13'h0001) begin
                    tx_line_cnt_r <= 13'h0000;
                    tx_line_sof_r <= 1'b1;
                end else begin
                    tx_line_cnt_r <= tx_line_cnt_r + 13'h0001;
                end
            end
        end
    end

    // datacom terminal timing; ticks and frame starts only in the two datacom modes
    assign datacom_mode = (cfg.tx_mode == TXM_DC_SERIAL) || (cfg.tx_mode == TXM_DC_PARALLEL);
    assign dc_frame_active = pulse_active(lvl[PIN_DC_FRAME],
                                          cfg.tx_mode == TXM_DC_SERIAL);

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            tx_term_tick_r <= 1'b0;
            tx_term_sof_r <= 1'b0;
        end else begin
            tx_term_tick_r <= datacom_mode & rise[PIN_DC_CLK];
            tx_term_sof_r <= datacom_mode & rise[PIN_DC_CLK] & dc_frame_active;
        end
    end

    assign rx_bit = rx_bit_r;
    assign rx_bit_valid = rx_bit_valid_r;
    assign rx_line_frame_mark = rx_frame_mark_r;
    assign rx_term_tick = rx_term_tick_r;
    assign rx_term_sof = rx_term_sof_r;
    assign tx_line_clock_out = tx_clk_r;
    assign tx_line_serial_out = tx_data_r;
    assign tx_bit_req = tx_req_r;
    assign tx_line_sof = tx_line_sof_r;
    assign tx_term_tick = tx_term_tick_r;
    assign tx_term_sof = tx_term_sof_r;
    assign status = '{loss_of_signal_status: los_r,
                      out_of_frame: frame_state_r == ST_OUT_OF_FRAME,
                      frame_pulse_used: frame_pulse_used_r};
endmodule : line_side_io
`default_nettype wire

// ---- hdl/line_side_pkg.sv ----
// Purpose: shared types and constants for the line-side and reference-input block
// Assumes: every external clock is slow enough to be sampled by ref_clk
// Notes: frame lengths are per 125 us frame at each reference rate
//
// Overview of operation
// - rx reference clock retimes only when selected
// - rx reference frame low at 51.84, else high
// - without rx reference frame, start is free
// - tx line frame aligns to low reference
// - tx line clock input retimes when selected, else per mode
// - datacom frame: low serial, high otherwise
// - line frame pulse: out-of-frame exit one frame
// - line frame pulse only when single-channel zero
// - line data sampled on line clock rise
// - external loss ORed with internal loss detection
// - tx data changes on output clock fall
// - tx clock out from selected source
package line_side_pkg;
    typedef enum logic [1:0] {RATE_51M84, RATE_19M44, RATE_6M48} ref_rate_t;
    typedef enum logic [1:0] {TXM_SONET, TXM_LOOP, TXM_DC_SERIAL, TXM_DC_PARALLEL} tx_mode_t;

    typedef struct packed {
        logic rx_ref_clock_select;
        ref_rate_t rx_ref_rate;
        logic tx_clock_source_select;
        tx_mode_t tx_mode;
        logic single_channel_mode_bit;
        logic multiframe_ind_internal;
        logic tx_frame_align_en;
    } line_cfg_t;

    typedef struct packed {
        logic loss_of_signal_status;
        logic out_of_frame;
        logic frame_pulse_used;
    } line_status_t;

    localparam int CLK_PERIOD_NS = 50;
    localparam logic [12:0] FRAME_BITS = 13'h1950;       // 6480 bits at 51.84
    localparam logic [12:0] FRAME_BYTES_19M44 = 13'h097E; // 2430 bytes
    localparam logic [12:0] FRAME_BYTES_6M48 = 13'h032A;  // 810 bytes
    localparam logic [1:0] OOF_EXIT_WITH_PULSE = 2'h1;
    localparam logic [1:0] OOF_EXIT_NORMAL = 2'h2;
    localparam int LOS_MIN_LOW_NS = 20;
    localparam int LOS_MIN_LOW_CYC_I = (LOS_MIN_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] LOS_MIN_LOW_CYC = LOS_MIN_LOW_CYC_I[3:0];
    localparam int NO_CLK_NS = 4000;
    localparam int NO_CLK_CYC_I = NO_CLK_NS / CLK_PERIOD_NS;
    localparam logic [7:0] NO_CLK_CYC = NO_CLK_CYC_I[7:0];

    // pin sampler lane positions
    localparam int PIN_RX_CLK = 0;
    localparam int PIN_RX_DATA = 1;
    localparam int PIN_RX_FRAME = 2;
    localparam int PIN_EXT_LOS_N = 3;
    localparam int PIN_RREF_CLK = 4;
    localparam int PIN_RREF_FRAME = 5;
    localparam int PIN_TX_CLK = 6;
    localparam int PIN_TX_FRAME_N = 7;
    localparam int PIN_DC_CLK = 8;
    localparam int PIN_DC_FRAME = 9;
    localparam int PIN_TERM_CLK = 10;
    localparam int PIN_COUNT = 11;
endpackage : line_side_pkg

// ---- hdl/pin_sampler.sv ----
// Purpose: three-stage sampler with agreement filter and edge pulses
// Assumes: pins are asynchronous to ref_clk
// Notes: a change counts only once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module pin_sampler #(
    parameter int WIDTH = 1
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] pin,
    output logic [WIDTH-1:0] level,
    output logic [WIDTH-1:0] rise,
    output logic [WIDTH-1:0] fall
);
    logic [WIDTH-1:0] s1_r;
    logic [WIDTH-1:0] s2_r;
    logic [WIDTH-1:0] s3_r;
    logic [WIDTH-1:0] level_r;
    logic [WIDTH-1:0] level_nxt;

    // stage one feeds stage two only, keeping metastability out of logic
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end else begin
            s1_r <= pin;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // hold the last agreed value while the late stages disagree
    always_comb begin
        level_nxt = (s2_r & s3_r) | (level_r & (s2_r | s3_r));
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            level_r <= '0;
        end else begin
            level_r <= level_nxt;
        end
    end

    assign level = level_r;
    assign rise = level_nxt & ~level_r;
    assign fall = ~level_nxt & level_r;
endmodule : pin_sampler
`default_nettype wire

// ---- test/line_side_io_sva.sv ----
// Purpose: port-level checker for the line-side block
// Assumes: pin clocks run far below ref_clk
// Notes: windows allow for the three-stage pin samplers
`timescale 1ns/1ps
`default_nettype none
module line_side_io_sva
    import line_side_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire line_cfg_t cfg,
    input wire logic ext_loss_of_signal_n,
    input wire logic internal_los,
    input wire logic tx_line_clock_in,
    input wire logic framing_match,
    input wire logic framing_lost,
    input wire logic rx_bit_valid,
    input wire logic rx_line_frame_mark,
    input wire logic tx_line_clock_out,
    input wire logic tx_line_serial_out,
    input wire logic tx_bit_req,
    input wire line_status_t status
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // six samples high is past any sampler latency
    sequence s_src_high;
        (cfg.tx_clock_source_select && tx_line_clock_in) [*6];
    endsequence
    sequence s_ext_low;
        (!ext_loss_of_signal_n) [*4];
    endsequence
    property p_valid_pulse;
        rx_bit_valid |=> !rx_bit_valid;
    endproperty
    a_valid_pulse: assert property (p_valid_pulse) else $error("valid too long");
    property p_mark_gate;
        rx_line_frame_mark |-> rx_bit_valid && !cfg.single_channel_mode_bit;
    endproperty
    a_mark_gate: assert property (p_mark_gate) else $error("stray frame mark");
    property p_data_on_fall;
        $changed(tx_line_serial_out) |-> $fell(tx_line_clock_out);
    endproperty
    a_data_on_fall: assert property (p_data_on_fall) else $error("data off fall");
    property p_req_on_fall;
        tx_bit_req |-> $fell(tx_line_clock_out);
    endproperty
    a_req_on_fall: assert property (p_req_on_fall) else $error("req off fall");
    property p_clk_follow;
        s_src_high |-> tx_line_clock_out;
    endproperty
    a_clk_follow: assert property (p_clk_follow) else $error("clock out lost");
    property p_int_los;
        internal_los |=> status.loss_of_signal_status;
    endproperty
    a_int_los: assert property (p_int_los) else $error("internal loss missed");
    property p_ext_los;
        s_ext_low |-> ##[0:3] status.loss_of_signal_status;
    endproperty
    a_ext_los: assert property (p_ext_los) else $error("external loss missed");
    property p_oof_fast;
        status.frame_pulse_used && status.out_of_frame && framing_match && !framing_lost
            |=> !status.out_of_frame;
    endproperty
    a_oof_fast: assert property (p_oof_fast) else $error("slow frame exit");
    property p_lost;
        framing_lost |=> status.out_of_frame;
    endproperty
    a_lost: assert property (p_lost) else $error("frame loss ignored");
endmodule : line_side_io_sva
bind line_side_io line_side_io_sva chk (
    .ref_clk, .rst_n, .cfg, .ext_loss_of_signal_n, .internal_los, .tx_line_clock_in,
    .framing_match, .framing_lost, .rx_bit_valid, .rx_line_frame_mark,
    .tx_line_clock_out, .tx_line_serial_out, .tx_bit_req, .status
);
`default_nettype wire

// ---- test/line_unit_model.sv ----
// Purpose: far-end line unit driving the receive line pins
// Assumes: run is raised only after reset
// Notes: a frame is cut to 16 bits so runs stay short
`timescale 1ns/1ps
`default_nettype none
module line_unit_model (
    input wire logic run,
    output logic rx_line_clock_in,
    output logic rx_line_serial_in,
    output logic rx_line_frame_pulse
);
    int unsigned bit_idx = 0;
    // 400 ns clock that stops low; data moves on the fall to stay clear of the rise
    initial begin
        rx_line_clock_in = 1'b0;
        rx_line_serial_in = 1'b0;
        rx_line_frame_pulse = 1'b1;
        forever begin
            #200;
            if (run || rx_line_clock_in) begin
                rx_line_clock_in = ~rx_line_clock_in;
                if (!rx_line_clock_in) begin
                    bit_idx = (bit_idx + 1) % 16;
                    rx_line_serial_in = 1'($urandom);
                    rx_line_frame_pulse = (bit_idx != 6); // low in one slot
                end
            end
        end
    end
endmodule : line_unit_model
`default_nettype wire

// ---- test/test_line_side_io.sv ----
// Purpose: self-checking bench for the line-side block
// Assumes: tx source is the tx line clock input throughout
// Notes: notes are queued at pin edges and matched at output pulses
`timescale 1ns/1ps
`default_nettype none
module test_line_side_io import line_side_pkg::*;;
    logic ref_clk = 1'b0;
    logic rst_n, internal_los, ext_n, match, lost, tx_clk, tx_bit, rx_run, tx_run;
    logic rx_clk, rx_data, rx_frame_n, rx_bit, rx_valid, rx_mark, tx_out_clk, tx_out;
    logic tx_req, tx_fref_n, rx_tick, rx_tsof, tx_sof, dc_tick, dc_sof;
    logic [1:0] rx_note, tx_note;
    line_cfg_t cfg;
    line_status_t status;
    logic [1:0] rxq[$];
    logic [1:0] txq[$];
    int num_errors = 0;
    int check_count = 0;
    int tx_div = 0;

    always #25 ref_clk = ~ref_clk;

    line_unit_model lu (.run(rx_run), .rx_line_clock_in(rx_clk),
        .rx_line_serial_in(rx_data), .rx_line_frame_pulse(rx_frame_n));

    line_side_io dut (.ref_clk(ref_clk), .rst_n(rst_n), .cfg(cfg),
        .rx_line_clock_in(rx_clk), .rx_line_serial_in(rx_data),
        .rx_line_frame_pulse(rx_frame_n), .ext_loss_of_signal_n(ext_n),
        .internal_los(internal_los), .rx_ref_clock_in(rx_clk),
        .rx_ref_frame_in(1'b1), // optional at the 51.84 rate, held idle
        .tx_line_clock_in(tx_clk), .tx_frame_ref_in(tx_fref_n),
        .datacom_ref_clock_in(tx_clk), // a datacom clock runs whenever the tx source clock does
        .datacom_ref_frame_in(1'b1), // frame pin left unused
        .tx_terminal_serial_clock(rx_clk),
        .framing_match(match), .framing_lost(lost), .tx_bit_in(tx_bit), .rx_bit(rx_bit),
        .rx_bit_valid(rx_valid), .rx_line_frame_mark(rx_mark), .rx_term_tick(rx_tick),
        .rx_term_sof(rx_tsof), .tx_line_clock_out(tx_out_clk), .tx_line_serial_out(tx_out),
        .tx_bit_req(tx_req), .tx_line_sof(tx_sof), .tx_term_tick(dc_tick),
        .tx_term_sof(dc_sof), .status(status));

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : tally_and_finish

    task automatic check_stream(input logic [1:0] got, input logic [1:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected stream at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : check_stream

    task automatic check_flag(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected flag at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : check_flag

    // one framing pulse, then settle to the following falling edge
    task automatic pulse(input logic is_lost);
        @(posedge ref_clk);
        match <= !is_lost;
        lost <= is_lost;
        @(posedge ref_clk);
        match <= 1'b0;
        lost <= 1'b0;
        @(negedge ref_clk);
    endtask : pulse

    // notes still open, or a stopped link clock not yet parked low
    function automatic logic busy();
        return (rxq.size() + txq.size()) > 0 || rx_clk || (!tx_run && tx_clk);
    endfunction : busy

    // drain both note queues and park the clocks; a stuck queue means a lost bit
    task automatic settle();
        @(posedge ref_clk);
        for (int i = 0; i < 200 && busy(); i++) @(posedge ref_clk);
        if (busy()) begin
            num_errors++;
            tally_and_finish();
        end
    endtask : settle

    // note each line bit as the far end clocks it in
    always @(posedge rx_clk) rxq.push_back({!rx_frame_n && !cfg.single_channel_mode_bit, rx_data});

    // tx source clock; stops only while low so no bit is cut in half
    always @(posedge ref_clk) begin
        tx_div <= (tx_div + 1) % 4;
        if (tx_div == 3 && (tx_run || tx_clk)) begin
            tx_clk <= ~tx_clk;
            if (tx_clk) begin
                txq.push_back({cfg.tx_frame_align_en && !tx_fref_n, tx_bit});
            end else begin
                tx_bit <= 1'($urandom);
                tx_fref_n <= ($urandom % 8) != 0; // frame reference held for a whole bit
            end
        end
    end

    // match the oldest note to each output pulse; an empty queue never matches
    always @(posedge ref_clk) begin
        if (rst_n && rx_valid) begin
            rx_note = rxq.size() ? rxq.pop_front() : 2'bxx;
            check_stream({rx_mark, rx_bit}, rx_note);
            check_stream({rx_tick, rx_tsof}, 2'b10);
        end
        if (rst_n && tx_req) begin
            tx_note = txq.size() ? txq.pop_front() : 2'bxx;
            check_stream({tx_sof, tx_out}, tx_note);
            check_stream({tx_out_clk, dc_tick | dc_sof}, 2'b00);
        end
    end

    initial begin
        rst_n = 1'b0;
        cfg = '0;
        cfg.tx_clock_source_select = 1'b1;
        cfg.tx_frame_align_en = 1'b1;
        tx_fref_n = 1'b1;
        {internal_los, match, lost, tx_clk, tx_bit, rx_run, tx_run} = '0;
        ext_n = 1'b1;
        void'($urandom(1));
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        rx_run <= 1'b1;
        tx_run <= 1'b1;
        repeat (300) @(negedge ref_clk);
        check_flag(status.loss_of_signal_status, 1'b0);
        check_flag(status.frame_pulse_used, 1'b1);
        pulse(1'b0);
        check_flag(status.out_of_frame, 1'b0);
        pulse(1'b1);
        check_flag(status.out_of_frame, 1'b1);
        @(posedge ref_clk);
        internal_los <= 1'b1;
        @(posedge ref_clk);
        internal_los <= 1'b0;
        @(negedge ref_clk);
        check_flag(status.loss_of_signal_status, 1'b1);
        @(posedge ref_clk);
        ext_n <= 1'b0;
        repeat (7) @(negedge ref_clk);
        check_flag(status.loss_of_signal_status, 1'b1);
        @(posedge ref_clk);
        ext_n <= 1'b1;
        // marks must vanish and frame exit needs two matches again
        rx_run <= 1'b0;
        settle();
        cfg.single_channel_mode_bit <= 1'b1;
        rx_run <= 1'b1;
        repeat (200) @(negedge ref_clk);
        check_flag(status.frame_pulse_used, 1'b0);
        pulse(1'b0);
        check_flag(status.out_of_frame, 1'b1);
        pulse(1'b0);
        check_flag(status.out_of_frame, 1'b0);
        // quiet both streams, then reset with both runs stopped
        rx_run <= 1'b0;
        tx_run <= 1'b0;
        settle();
        rst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(negedge ref_clk);
        check_flag(status.out_of_frame, 1'b1);
        // an idle high loss pin must not read as a loss once the samplers refill
        repeat (4) @(negedge ref_clk);
        check_flag(status.loss_of_signal_status, 1'b0);
        tally_and_finish();
    end
endmodule : test_line_side_io
`default_nettype wire
